// File: rtl/pswb_top.sv
// status word and second accumulator with the flag update datapath
// assumes the core presents decoded arith ops and special-register accesses,
// one per enabled cycle, with the accumulator value supplied by the core
//
// Function
// RQ1 - second accumulator: eight-bit read/write, bit access, address F0, reset zero
// RQ2 - second accumulator is operand and result for multiply and divide
// RQ3 - status word: bit access, address D0, all pages, reset zero
// RQ4 - carry bit 7 set on add carry-out or subtract borrow, else cleared
// RQ5 - overflow bit 2 set on signed overflow of add, add_with_carry_op, subtract_with_borrow_op
// RQ6 - overflow set when multiply product exceeds 255
// RQ7 - overflow set on divide by zero
// RQ8 - arith ops clear overflow when no overflow condition occurs
// RQ9 - parity bit 0 read-only, odd count of accumulator ones
// RQ10 - user flags bits 5 and 1 are plain software storage
// RQ11 - bank select bits 4:3 give working register base 8 times n
// RQ12 - aux carry bit 6 set on carry out of or borrow into bit 3
`timescale 1ns/1ps
`include "pswb_consts.svh"
module pswb_top (
	// clock and reset
	input  wire logic                 clock_in,
	input  wire logic                 resetn_in,
	input  wire logic                 clk_en_in,
	// arithmetic request
	input  wire pswb_pkg::pswb_op_type op_in,
	input  wire logic           [7:0] acc_in,
	input  wire logic           [7:0] operand_in,
	// special register access, direct address
	input  wire logic           [7:0] sfr_addr_in,
	input  wire logic                 sfr_byte_wr_in,
	input  wire logic                 sfr_bit_wr_in,
	input  wire logic           [2:0] sfr_bit_sel_in,
	input  wire logic                 sfr_bit_val_in,
	input  wire logic           [7:0] sfr_wdata_in,
	input  wire logic                 sfr_rd_in,
	// results to the core
	output logic                [7:0] sfr_rdata_out,
	output logic                [7:0] psw_out,
	output logic                [7:0] sacc_out,
	output logic                [7:0] acc_result_out,
	output logic                [4:0] bank_base_out
);
	// a flag is written by software only when the direct address selects it
	function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ref_a);
		addr_hit = (a == ref_a);
	endfunction : addr_hit

	logic       hit_psw;
	logic       hit_sacc;
	logic [8:0] add_sum;
	logic [4:0] add_nib;
	logic [8:0] sub_dif;
	logic [4:0] sub_nib;
	logic [15:0] product;
	logic [7:0] quot;
	logic [7:0] remd;
	logic       cin;
	logic       is_add;
	logic       is_sub;
	logic       is_mul;
	logic       is_div;
	logic       arith;
	logic       ov_new;
	logic       cy_new;
	logic       ac_new;
	logic [7:0] psw_hw;
	logic [7:0] psw_q;
	logic [7:0] sacc_q;
	logic [7:0] acc_res;
	logic [7:0] sacc_res;
	logic       acc_par;
	logic [7:0] rdata_d;
	logic [7:0] acc_q;
	logic       psw_sw_wr;

	assign hit_psw  = addr_hit(sfr_addr_in, `PSWB_ADDR_PSW);   // RQ3
	assign hit_sacc = addr_hit(sfr_addr_in, `PSWB_ADDR_SACC);  // RQ1
	// a dropped parity-bit write leaves the arith update in place
	assign psw_sw_wr = hit_psw && (sfr_byte_wr_in ||
		(sfr_bit_wr_in && (sfr_bit_sel_in != `PSWB_BIT_PAR)));

	assign is_add = (op_in == pswb_pkg::PSWB_OP_ADD) || (op_in == pswb_pkg::PSWB_OP_ADD_WITH_CARRY_OP);
	assign is_sub = (op_in == pswb_pkg::PSWB_OP_SUBTRACT_WITH_BORROW_OP);
	assign is_mul = (op_in == pswb_pkg::PSWB_OP_MUL);
	assign is_div = (op_in == pswb_pkg::PSWB_OP_DIV);
	assign arith  = is_add || is_sub || is_mul || is_div;
	assign cin    = (op_in == pswb_pkg::PSWB_OP_ADD) ? 1'b0 : psw_q[`PSWB_BIT_CY];

	assign add_sum = {1'b0, acc_in} + {1'b0, operand_in} + {8'h00, cin};
	assign add_nib = {1'b0, acc_in[3:0]} + {1'b0, operand_in[3:0]} + {4'h0, cin};
	assign sub_dif = {1'b0, acc_in} - {1'b0, operand_in} - {8'h00, cin};
	assign sub_nib = {1'b0, acc_in[3:0]} - {1'b0, operand_in[3:0]} - {4'h0, cin};
	// multiply and divide use the second accumulator as the other operand
	assign product = {8'h00, acc_in} * {8'h00, sacc_q};                 // RQ2
	assign quot    = (sacc_q == 8'h00) ? 8'hFF : acc_in / sacc_q;
	assign remd    = (sacc_q == 8'h00) ? acc_in : acc_in % sacc_q;

	always_comb begin
		ov_new   = 1'b0;                                            // RQ8
		cy_new   = psw_q[`PSWB_BIT_CY];
		ac_new   = psw_q[`PSWB_BIT_AC];
		acc_res  = acc_in;
		sacc_res = sacc_q;
		if (is_add) begin
			acc_res = add_sum[7:0];
			cy_new  = add_sum[8];                                   // RQ4
			ac_new  = add_nib[4];                                   // RQ12
			ov_new  = (acc_in[7] == operand_in[7]) && (add_sum[7] != acc_in[7]); // RQ5
		end else if (is_sub) begin
			acc_res = sub_dif[7:0];
			cy_new  = sub_dif[8];                                   // RQ4
			ac_new  = sub_nib[4];                                   // RQ12
			ov_new  = (acc_in[7] != operand_in[7]) && (sub_dif[7] != acc_in[7]); // RQ5
		end else if (is_mul) begin
			acc_res  = product[7:0];
			sacc_res = product[15:8];                               // RQ2
			cy_new   = 1'b0;
			ov_new   = (product[15:8] != 8'h00);                    // RQ6
		end else if (is_div) begin
			acc_res  = quot;
			sacc_res = remd;                                        // RQ2
			cy_new   = 1'b0;
			ov_new   = (sacc_q == 8'h00);                           // RQ7
		end
	end

	// parity of the accumulator copy, so it lines up with the stored flags
	assign acc_par = ^acc_q;                                            // RQ9

	// user flags and bank select keep their value unless software writes
	assign psw_hw = {cy_new, ac_new, psw_q[5:3], ov_new, psw_q[1], 1'b0}; // RQ10

	pswb_byte_reg u_psw (
		.clock_in     (clock_in),
		.resetn_in    (resetn_in),
		.clk_en_in    (clk_en_in),
		.hw_load_in   (arith),
		.hw_data_in   (psw_hw),
		.byte_wr_in   (sfr_byte_wr_in && hit_psw),
		.byte_data_in ({sfr_wdata_in[7:1], 1'b0}),
		.bit_wr_in    (sfr_bit_wr_in && hit_psw && (sfr_bit_sel_in != `PSWB_BIT_PAR)),
		.bit_sel_in   (sfr_bit_sel_in),
		.bit_val_in   (sfr_bit_val_in),
		.value_out    (psw_q)
	);

	pswb_byte_reg u_sacc (
		.clock_in     (clock_in),
		.resetn_in    (resetn_in),
		.clk_en_in    (clk_en_in),
		.hw_load_in   (is_mul || is_div),
		.hw_data_in   (sacc_res),
		.byte_wr_in   (sfr_byte_wr_in && hit_sacc),                  // RQ1
		.byte_data_in (sfr_wdata_in),
		.bit_wr_in    (sfr_bit_wr_in && hit_sacc),
		.bit_sel_in   (sfr_bit_sel_in),
		.bit_val_in   (sfr_bit_val_in),
		.value_out    (sacc_q)
	);

	assign rdata_d = hit_psw ? {psw_q[7:1], acc_par} : (hit_sacc ? sacc_q : 8'h00);

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			acc_q          <= 8'h00;
			psw_out        <= 8'h00;
			sacc_out       <= 8'h00;
			acc_result_out <= 8'h00;
			bank_base_out  <= 5'h00;
			sfr_rdata_out  <= 8'h00;
		end else if (clk_en_in) begin
			acc_q          <= arith ? acc_res : acc_in;
			psw_out        <= {psw_q[7:1], acc_par};
			sacc_out       <= sacc_q;
			acc_result_out <= acc_q;
			bank_base_out  <= {psw_q[4:3], 3'h0};                   // RQ11
			if (sfr_rd_in) begin
				sfr_rdata_out <= rdata_d;
			end
		end
	end

	a_div_zero_ov: assert property (@(posedge clock_in) disable iff (!resetn_in) // RQ7
		clk_en_in && is_div && sacc_q == 8'h00 && !psw_sw_wr |=> psw_q[`PSWB_BIT_OV])
		else $error("divide by zero left overflow clear");
	a_mul_ov_big: assert property (@(posedge clock_in) disable iff (!resetn_in) // RQ6
		clk_en_in && is_mul && !psw_sw_wr
		|=> psw_q[`PSWB_BIT_OV] == (({8'h00, $past(acc_in)} * {8'h00, $past(sacc_q)}) > 16'h00FF))
		else $error("multiply overflow flag wrong");
	a_add_carry: assert property (@(posedge clock_in) disable iff (!resetn_in) // RQ4
		clk_en_in && is_add && !sfr_byte_wr_in && !sfr_bit_wr_in
		|=> psw_q[`PSWB_BIT_CY] == $past(add_sum[8]))
		else $error("carry after add wrong");
	a_sub_aux: assert property (@(posedge clock_in) disable iff (!resetn_in) // RQ12
		clk_en_in && is_sub && !sfr_byte_wr_in && !sfr_bit_wr_in
		|=> psw_q[`PSWB_BIT_AC] == $past(sub_nib[4]))
		else $error("aux carry after subtract wrong");
	a_add_ov_sign: assert property (@(posedge clock_in) disable iff (!resetn_in) // RQ5
		clk_en_in && is_add && !psw_sw_wr && acc_in == 8'h7F && operand_in == 8'h01
		|=> psw_q[`PSWB_BIT_OV])
		else $error("signed overflow missed");
	a_ov_cleared: assert property (@(posedge clock_in) disable iff (!resetn_in) // RQ8
		clk_en_in && arith && !ov_new && !sfr_byte_wr_in && !sfr_bit_wr_in
		|=> !psw_q[`PSWB_BIT_OV])
		else $error("overflow not cleared");
	a_parity_out: assert property (@(posedge clock_in) disable iff (!resetn_in) // RQ9
		clk_en_in |=> psw_out[0] == ^$past(acc_q))
		else $error("parity output wrong");
	a_bank_base: assert property (@(posedge clock_in) disable iff (!resetn_in) // RQ11
		clk_en_in ##1 clk_en_in |=> bank_base_out == {$past(psw_q[4:3]), 3'h0})
		else $error("bank base wrong");
	a_user_hold: assert property (@(posedge clock_in) disable iff (!resetn_in) // RQ10
		clk_en_in && !(hit_psw && (sfr_byte_wr_in || sfr_bit_wr_in))
		|=> psw_q[5] == $past(psw_q[5]) && psw_q[1] == $past(psw_q[1]))
		else $error("user flag changed by hardware");
	a_sacc_write: assert property (@(posedge clock_in) disable iff (!resetn_in) // RQ1
		clk_en_in && sfr_byte_wr_in && hit_sacc |=> sacc_q == $past(sfr_wdata_in))
		else $error("second accumulator write lost");
endmodule : pswb_top

// File: rtl/pswb_consts.svh
// constants for status word and second accumulator block
// assumes inclusion by bare name from rtl files
`ifndef PSWB_CONSTS_SVH
`define PSWB_CONSTS_SVH
`define PSWB_ADDR_PSW     8'hD0
`define PSWB_ADDR_SACC    8'hF0
`define PSWB_RESET_VAL    8'h00
`define PSWB_BIT_CY       3'h7
`define PSWB_BIT_AC       3'h6
`define PSWB_BIT_F0       3'h5
`define PSWB_BIT_RS_HI    3'h4
`define PSWB_BIT_RS_LO    3'h3
`define PSWB_BIT_OV       3'h2
`define PSWB_BIT_F1       3'h1
`define PSWB_BIT_PAR      3'h0
`define PSWB_BANK_SHIFT   3
`endif

// File: rtl/pswb_pkg.sv
// types for status word and second accumulator block
// assumes nothing beyond the consts header
package pswb_pkg;
	typedef enum logic [2:0] {
		PSWB_OP_NONE,
		PSWB_OP_ADD,
		PSWB_OP_ADD_WITH_CARRY_OP,
		PSWB_OP_SUBTRACT_WITH_BORROW_OP,
		PSWB_OP_MUL,
		PSWB_OP_DIV
	} pswb_op_type;
endpackage : pswb_pkg

// File: rtl/pswb_byte_reg.sv
// one byte register with bit and byte write, registered read data
// assumes writes are single-cycle strobes in the core clock domain
`timescale 1ns/1ps
`include "pswb_consts.svh"
module pswb_byte_reg (
	// clock and reset
	input  wire logic       clock_in,
	input  wire logic       resetn_in,
	input  wire logic       clk_en_in,
	// hardware load (arith result), loses to software write
	input  wire logic       hw_load_in,
	input  wire logic [7:0] hw_data_in,
	// software writes
	input  wire logic       byte_wr_in,
	input  wire logic [7:0] byte_data_in,
	input  wire logic       bit_wr_in,
	input  wire logic [2:0] bit_sel_in,
	input  wire logic       bit_val_in,
	// value
	output logic      [7:0] value_out
);
	logic [7:0] value_d;
	logic [7:0] bit_mask;

	assign bit_mask = 8'h01 << bit_sel_in;

	always_comb begin
		value_d = value_out;
		if (hw_load_in) begin
			value_d = hw_data_in;
		end
		if (byte_wr_in) begin
			value_d = byte_data_in;
		end else if (bit_wr_in) begin
			value_d = bit_val_in ? (value_out | bit_mask) : (value_out & ~bit_mask);
		end
	end

	always_ff @(posedge clock_in or negedge resetn_in) begin
		if (!resetn_in) begin
			value_out <= `PSWB_RESET_VAL;
		end else if (clk_en_in) begin
			value_out <= value_d;
		end
	end
endmodule : pswb_byte_reg

// File: verification/test_status_word_and_second_accumulator.sv
// self-checking bench for the status word and second accumulator block
// assumes the rtl package and consts header are compiled first
`timescale 1ns/1ps
`include "pswb_consts.svh"
module test_status_word_and_second_accumulator;
	logic                  clock_in, resetn_in, clk_en_in, sfr_rd_in, nv;
	logic                  sfr_byte_wr_in, sfr_bit_wr_in, sfr_bit_val_in;
	pswb_pkg::pswb_op_type op_in;
	logic [7:0]            acc_in, operand_in, sfr_addr_in, sfr_wdata_in;
	logic [7:0]            sfr_rdata_out, psw_out, sacc_out, acc_result_out;
	logic [7:0]            psw_m, sacc_m, acc_m, rn;
	logic [7:0]            rnotes[$];
	logic                  rdv, rdv_q;
	logic [2:0]            sfr_bit_sel_in;
	logic [4:0]            bank_base_out;
	logic [1:0]            nv_d;
	logic [47:0]           notes[$];
	logic [47:0]           n;
	logic [31:0]           seed, r;
	int                    bad_count, checks_done;
	pswb_top u_pswb_top (.clock_in(clock_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
		.op_in(op_in), .acc_in(acc_in), .operand_in(operand_in), .sfr_addr_in(sfr_addr_in),
		.sfr_byte_wr_in(sfr_byte_wr_in), .sfr_bit_wr_in(sfr_bit_wr_in),
		.sfr_bit_sel_in(sfr_bit_sel_in), .sfr_bit_val_in(sfr_bit_val_in),
		.sfr_wdata_in(sfr_wdata_in), .sfr_rd_in(sfr_rd_in), .sfr_rdata_out(sfr_rdata_out),
		.psw_out(psw_out), .sacc_out(sacc_out), .acc_result_out(acc_result_out),
		.bank_base_out(bank_base_out));
	initial begin
		clock_in = 1'b0;
		forever #10 clock_in = ~clock_in;
	end
	function automatic logic [31:0] xorshift(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		xorshift = y ^ (y << 5);
	endfunction : xorshift
	task end_sim;
		if (bad_count == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : end_sim
	task check8(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check8
	// results show one edge after the request edge, read data at the request edge
	always @(posedge clock_in or negedge resetn_in)
		if (!resetn_in) {nv_d, rdv_q} <= 3'h0;
		else {nv_d, rdv_q} <= {nv_d[0], nv, rdv};
	always @(negedge clock_in) begin
		if (nv_d[1]) begin
			n = notes.pop_front();
			check8(psw_out, n[7:0]);
			check8(sacc_out, n[15:8]);
			check8(acc_result_out, n[23:16]);
			check8({3'h0, bank_base_out}, n[31:24]);
		end
		// read data is replaced by the next read, so it is looked at one edge in
		if (rdv_q) begin
			rn = rnotes.pop_front();
			check8(sfr_rdata_out, rn);
		end
	end
	task step(input logic en, input logic [2:0] op, input logic [7:0] a, input logic [7:0] b,
		input logic [7:0] ad, input logic bw, input logic tw, input logic [2:0] sel,
		input logic val, input logic [7:0] wd, input logic rd);
		logic [8:0] s;
		logic [4:0] h;
		logic [15:0] p;
		logic [7:0] np, ns, na, rv;
		@(negedge clock_in);
		{clk_en_in, acc_in, operand_in, sfr_addr_in, sfr_byte_wr_in} = {en, a, b, ad, bw};
		{sfr_bit_wr_in, sfr_bit_sel_in, sfr_bit_val_in, sfr_wdata_in, sfr_rd_in} = {tw, sel, val, wd, rd};
		op_in = pswb_pkg::pswb_op_type'(op);
		np = psw_m;
		ns = sacc_m;
		na = en ? a : acc_m;
		rv = (ad == `PSWB_ADDR_PSW) ? (psw_m | {7'h00, ^acc_m}) : (ad == `PSWB_ADDR_SACC) ? sacc_m : 8'h00;
		if (en) begin
			case (op)
				3'h1, 3'h2: begin
					s = a + b + (op == 3'h2 ? psw_m[7] : 1'b0);
					h = a[3:0] + b[3:0] + (op == 3'h2 ? psw_m[7] : 1'b0);
					np[2] = (a[7] == b[7]) && (s[7] != a[7]);
				end
				3'h3: begin
					s = {1'b0, a} - b - psw_m[7];
					h = {1'b0, a[3:0]} - b[3:0] - psw_m[7];
					np[2] = (a[7] != b[7]) && (s[7] != a[7]);
				end
				3'h4: begin
					p = a * sacc_m;
					{ns, na} = p;
					np[2] = |p[15:8];
				end
				3'h5: begin
					na = (sacc_m == 8'h00) ? 8'hFF : a / sacc_m;
					ns = (sacc_m == 8'h00) ? a : a % sacc_m;
					np[2] = (sacc_m == 8'h00);
				end
				default: ;
			endcase
			if (op >= 3'h1 && op <= 3'h3) {na, np[7], np[6]} = {s[7:0], s[8], h[4]};
			if (op >= 3'h4) np[7] = 1'b0;
			// a parity-bit write is dropped, so the arith update still lands
			if (ad == `PSWB_ADDR_PSW && (bw || (tw && sel != 3'h0))) np = bw ? wd : psw_m;
			if (ad == `PSWB_ADDR_PSW && tw && !bw) np[sel] = val;
			if (ad == `PSWB_ADDR_SACC && (bw || tw)) ns = bw ? wd : sacc_m;
			if (ad == `PSWB_ADDR_SACC && tw && !bw) ns[sel] = val;
			np[0] = 1'b0;
			{psw_m, sacc_m, acc_m} = {np, ns, na};
		end
		notes.push_back({7'h00, rd & en, rv, 3'h0, np[4:3], 3'h0, na, ns, np | {7'h00, ^na}});
		nv = 1'b1;
		rdv = rd & en;
		if (rd & en) rnotes.push_back(rv);
	endtask : step
	task ar(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b);
		step(1'b1, op, a, b, 8'h00, 1'b0, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0);
	endtask : ar
	task rg(input logic [7:0] ad, input logic bw, input logic tw, input logic [2:0] sel,
		input logic [7:0] wd, input logic rd);
		step(1'b1, 3'h0, 8'h00, 8'h00, ad, bw, tw, sel, wd[0], wd, rd);
	endtask : rg
	task do_reset;
		@(negedge clock_in);
		nv = 1'b0;
		rdv = 1'b0;
		repeat (3) @(negedge clock_in);
		// idle the core side so no stale request lands after release
		{clk_en_in, sfr_byte_wr_in, sfr_bit_wr_in, sfr_rd_in} = 4'h0;
		op_in = pswb_pkg::PSWB_OP_NONE;
		resetn_in = 1'b0;
		repeat (20) @(negedge clock_in);
		check8(psw_out, 8'h00);
		check8(sacc_out, 8'h00);
		{psw_m, sacc_m, acc_m} = 24'h000000;
		resetn_in = 1'b1;
	endtask : do_reset
	initial begin
		{resetn_in, clk_en_in, nv, rdv, sfr_byte_wr_in, sfr_bit_wr_in, sfr_bit_val_in, sfr_rd_in} = 8'h00;
		{acc_in, operand_in, sfr_addr_in, sfr_wdata_in, sfr_bit_sel_in} = 35'h0;
		op_in = pswb_pkg::PSWB_OP_NONE;
		seed = 32'h0997;
		do_reset();
		ar(3'h1, 8'h7F, 8'h01);
		ar(3'h1, 8'hFF, 8'h01);
		ar(3'h2, 8'h00, 8'h00);
		ar(3'h3, 8'h00, 8'h01);
		ar(3'h3, 8'h80, 8'h01);
		rg(`PSWB_ADDR_SACC, 1'b1, 1'b0, 3'h0, 8'h10, 1'b0);
		ar(3'h4, 8'h20, 8'h00);
		ar(3'h4, 8'h03, 8'h00);
		rg(`PSWB_ADDR_SACC, 1'b1, 1'b0, 3'h0, 8'h00, 1'b0);
		ar(3'h5, 8'h37, 8'h00);
		ar(3'h5, 8'hC8, 8'h00);
		for (int i = 0; i < 4; i++) begin
			rg(`PSWB_ADDR_PSW, 1'b1, 1'b0, 3'h0, 8'(i << 3), 1'b0);
			rg(`PSWB_ADDR_PSW, 1'b0, 1'b0, 3'h0, 8'h00, 1'b1);
		end
		for (int i = 0; i < 8; i++) begin
			rg(`PSWB_ADDR_PSW, 1'b0, 1'b1, 3'(i), 8'(i + 1), 1'b1);
			rg(`PSWB_ADDR_SACC, 1'b0, 1'b1, 3'(i), 8'(i), 1'b1);
		end
		rg(`PSWB_ADDR_PSW, 1'b1, 1'b0, 3'h0, 8'hFF, 1'b1);
		rg(8'h55, 1'b1, 1'b0, 3'h0, 8'hAA, 1'b1);
		step(1'b0, 3'h1, 8'h7F, 8'h7F, 8'h00, 1'b0, 1'b0, 3'h0, 1'b0, 8'h00, 1'b0);
		repeat (400) begin
			seed = xorshift(seed);
			r = seed;
			step(1'b1, r[2:0] % 3'h6, r[15:8], r[23:16], r[25] ? (r[24] ? 8'h55 : `PSWB_ADDR_SACC)
				: `PSWB_ADDR_PSW, r[27:26] == 2'h0, r[27:26] == 2'h1, r[30:28], r[31], r[7:0], r[5]);
		end
		do_reset();
		ar(3'h1, 8'h01, 8'h01);
		do_reset();
		end_sim();
	end
	initial begin
		#100000;
		bad_count++;
		end_sim();
	end
endmodule : test_status_word_and_second_accumulator
